// [design/chd_channel_dividers.sv]
`timescale 1ns/10ps
module chd_channel_dividers (
    input  wire logic                       clock,
    input  wire logic                       rst_n,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [chd_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic                       distClkIn,
    input  wire logic                       oscIn,
    input  wire logic                       extClkIn,
    input  wire logic                       syncReq_n,
    output logic                            pairBFirstPin,
    output logic                            pairBSecondPin,
    output logic                            pairCFirstPin,
    output logic                            pairCSecondPin
);
    import chd_pkg::*;

    // ------------------------------------------------------------------
    // Pin synchronisers.
    // ------------------------------------------------------------------
    logic [3:0] pinMeta;
    logic [3:0] pinStable;
    logic [3:0] next_pinMeta;
    logic [3:0] next_pinStable;
    logic       distPrev;
    logic       syncPrev;
    logic       next_distPrev;
    logic       next_syncPrev;
    logic       distEdge;
    logic       syncEvt;

    always_comb begin
        next_pinMeta   = {syncReq_n, extClkIn, oscIn, distClkIn};
        next_pinStable = pinMeta;
        next_distPrev  = pinStable[0];
        next_syncPrev  = pinStable[3];
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pinMeta   <= 4'h8;
            pinStable <= 4'h8;
            distPrev  <= 1'b0;
            syncPrev  <= 1'b1;
        end else begin
            pinMeta   <= next_pinMeta;
            pinStable <= next_pinStable;
            distPrev  <= next_distPrev;
            syncPrev  <= next_syncPrev;
        end
    end

    // The divider input counts rising edges of the distribution clock;
    // a sync request is the falling edge of the active-low sync pin.
    assign distEdge = pinStable[0] && !distPrev;
    assign syncEvt  = syncPrev && !pinStable[3];

    // ------------------------------------------------------------------
    // Register file.
    // ------------------------------------------------------------------
    logic [REG_W-1:0] div1Counts;
    logic [REG_W-1:0] div1PolPh;
    logic [REG_W-1:0] div1Route;
    logic [REG_W-1:0] div2Counts;
    logic [REG_W-1:0] div2Ctrl;
    logic [REG_W-1:0] div2Route;
    logic [SRC_W-1:0] srcSelect;
    logic [REG_W-1:0] next_div1Counts;
    logic [REG_W-1:0] next_div1PolPh;
    logic [REG_W-1:0] next_div1Route;
    logic [REG_W-1:0] next_div2Counts;
    logic [REG_W-1:0] next_div2Ctrl;
    logic [REG_W-1:0] next_div2Route;
    logic [SRC_W-1:0] next_srcSelect;
    logic [31:0]      next_prdata;
    logic [REG_W-1:0] statusWord;
    logic             div1Out;
    logic             div2Out;
    logic             div1Run;
    logic             div2Run;
    logic             wrEn;
    logic             mapped;

    function automatic logic [ADDR_W-1:0] byteAddr(
        input logic [ADDR_W-1:0] idx);
        return {idx[ADDR_W-3:0], 2'b00};
    endfunction

    function automatic logic hits(input logic [ADDR_W-1:0] addr,
                                  input logic [ADDR_W-1:0] idx);
        return addr == byteAddr(idx);
    endfunction

    always_comb begin
        mapped = hits(paddr, IDX_DIV1_COUNTS) ||
                 hits(paddr, IDX_DIV1_POLPH)  ||
                 hits(paddr, IDX_DIV1_ROUTE)  ||
                 hits(paddr, IDX_DIV2_COUNTS) ||
                 hits(paddr, IDX_DIV2_CTRL)   ||
                 hits(paddr, IDX_DIV2_ROUTE)  ||
                 hits(paddr, IDX_SRC_SELECT)  ||
                 hits(paddr, IDX_STATUS);
    end

    assign pready  = psel && penable;
    assign pslverr = psel && penable && !mapped;
    assign wrEn    = psel && penable && pwrite && mapped;

    assign statusWord = {4'h0, div2Run, div1Run, div2Out, div1Out};

    always_comb begin
        next_div1Counts = div1Counts;
        next_div1PolPh  = div1PolPh;
        next_div1Route  = div1Route;
        next_div2Counts = div2Counts;
        next_div2Ctrl   = div2Ctrl;
        next_div2Route  = div2Route;
        next_srcSelect  = srcSelect;
        if (wrEn) begin
            if (hits(paddr, IDX_DIV1_COUNTS)) begin
                next_div1Counts = pwdata[REG_W-1:0];
            end
            if (hits(paddr, IDX_DIV1_POLPH)) begin
                next_div1PolPh = pwdata[REG_W-1:0];
            end
            if (hits(paddr, IDX_DIV1_ROUTE)) begin
                next_div1Route = pwdata[REG_W-1:0];
            end
            if (hits(paddr, IDX_DIV2_COUNTS)) begin
                next_div2Counts = pwdata[REG_W-1:0];
            end
            if (hits(paddr, IDX_DIV2_CTRL)) begin
                next_div2Ctrl = pwdata[REG_W-1:0];
            end
            if (hits(paddr, IDX_DIV2_ROUTE)) begin
                next_div2Route = pwdata[REG_W-1:0];
            end
            if (hits(paddr, IDX_SRC_SELECT)) begin
                next_srcSelect = pwdata[SRC_W-1:0];
            end
        end
    end

    // Read data is captured in the setup cycle, so it stands through
    // the whole access phase.
    always_comb begin
        next_prdata = prdata;
        if (psel && !penable) begin
            next_prdata = 32'h0000_0000;
            if (hits(paddr, IDX_DIV1_COUNTS)) begin
                next_prdata[REG_W-1:0] = div1Counts;
            end else if (hits(paddr, IDX_DIV1_POLPH)) begin
                next_prdata[REG_W-1:0] = div1PolPh;
            end else if (hits(paddr, IDX_DIV1_ROUTE)) begin
                next_prdata[REG_W-1:0] = div1Route;
            end else if (hits(paddr, IDX_DIV2_COUNTS)) begin
                next_prdata[REG_W-1:0] = div2Counts;
            end else if (hits(paddr, IDX_DIV2_CTRL)) begin
                next_prdata[REG_W-1:0] = div2Ctrl;
            end else if (hits(paddr, IDX_DIV2_ROUTE)) begin
                next_prdata[REG_W-1:0] = div2Route;
            end else if (hits(paddr, IDX_SRC_SELECT)) begin
                next_prdata[SRC_W-1:0] = srcSelect;
            end else if (hits(paddr, IDX_STATUS)) begin
                next_prdata[REG_W-1:0] = statusWord;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            div1Counts <= RST_DIV1_COUNTS;
            div1PolPh  <= RST_DIV1_POLPH;
            div1Route  <= RST_ROUTE;
            div2Counts <= RST_DIV2_COUNTS;
            div2Ctrl   <= RST_DIV2_CTRL;
            div2Route  <= RST_ROUTE;
            srcSelect  <= RST_SRC_SELECT;
            prdata     <= 32'h0000_0000;
        end else begin
            div1Counts <= next_div1Counts;
            div1PolPh  <= next_div1PolPh;
            div1Route  <= next_div1Route;
            div2Counts <= next_div2Counts;
            div2Ctrl   <= next_div2Ctrl;
            div2Route  <= next_div2Route;
            srcSelect  <= next_srcSelect;
            prdata     <= next_prdata;
        end
    end

    // ------------------------------------------------------------------
    // Channel dividers.
    // ------------------------------------------------------------------
    chd_divider u_div1 (
        .clock       (clock),
        .rst_n       (rst_n),
        .inEdge      (distEdge),
        .inLevel     (pinStable[0]),
        .syncEvt     (syncEvt),
        .lowCycles   (div1Counts[LOW_LSB +: NIB_W]),
        .highCycles  (div1Counts[HIGH_LSB +: NIB_W]),
        .phaseOffset (div1PolPh[PHASE_LSB +: NIB_W]),
        .bypass      (div1PolPh[BIT_BYPASS]),
        .noSync      (div1PolPh[BIT_NOSYNC]),
        .forceHigh   (div1PolPh[BIT_FORCE]),
        .startHigh   (div1PolPh[BIT_START]),
        .duty_correction_disable      (div1Route[BIT_DUTY_OFF]),
        .divOut      (div1Out),
        .running     (div1Run)
    );

    chd_divider u_div2 (
        .clock       (clock),
        .rst_n       (rst_n),
        .inEdge      (distEdge),
        .inLevel     (pinStable[0]),
        .syncEvt     (syncEvt),
        .lowCycles   (div2Counts[LOW_LSB +: NIB_W]),
        .highCycles  (div2Counts[HIGH_LSB +: NIB_W]),
        .phaseOffset (div2Ctrl[PHASE_LSB +: NIB_W]),
        .bypass      (div2Ctrl[BIT_BYPASS]),
        .noSync      (div2Ctrl[BIT_NOSYNC]),
        .forceHigh   (div2Ctrl[BIT_FORCE]),
        .startHigh   (div2Ctrl[BIT_START]),
        .duty_correction_disable      (div2Route[BIT_DUTY_OFF]),
        .divOut      (div2Out),
        .running     (div2Run)
    );

    // ------------------------------------------------------------------
    // Output pair routing.
    // ------------------------------------------------------------------
    chd_out_route u_pairB (
        .clock     (clock),
        .rst_n     (rst_n),
        .divLevel  (div1Out),
        .oscLevel  (pinStable[1]),
        .extLevel  (pinStable[2]),
        .direct    (div1Route[BIT_DIRECT]),
        .srcSelect (srcSelect),
        .firstPin  (pairBFirstPin),
        .secondPin (pairBSecondPin)
    );

    chd_out_route u_pairC (
        .clock     (clock),
        .rst_n     (rst_n),
        .divLevel  (div2Out),
        .oscLevel  (pinStable[1]),
        .extLevel  (pinStable[2]),
        .direct    (div2Route[BIT_DIRECT]),
        .srcSelect (srcSelect),
        .firstPin  (pairCFirstPin),
        .secondPin (pairCSecondPin)
    );

endmodule

// [design/chd_divider.sv]
`timescale 1ns/10ps
module chd_divider (
    input  wire logic                       clock,
    input  wire logic                       rst_n,
    input  wire logic                       inEdge,
    input  wire logic                       inLevel,
    input  wire logic                       syncEvt,
    input  wire logic [chd_pkg::NIB_W-1:0]  lowCycles,
    input  wire logic [chd_pkg::NIB_W-1:0]  highCycles,
    input  wire logic [chd_pkg::NIB_W-1:0]  phaseOffset,
    input  wire logic                       bypass,
    input  wire logic                       noSync,
    input  wire logic                       forceHigh,
    input  wire logic                       startHigh,
    input  wire logic                       duty_correction_disable,
    output logic                            divOut,
    output logic                            running
);
    import chd_pkg::*;

    chd_div_state_t   state;
    chd_div_state_t   next_state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic             level;
    logic             next_level;
    logic             swap;
    logic             next_swap;
    logic             next_divOut;
    logic [CNT_W-1:0] lenLow;
    logic [CNT_W-1:0] lenHigh;
    logic             oddPeriod;

    function automatic logic [CNT_W-1:0] phaseLen(
        input logic [NIB_W-1:0] field);
        return {1'b0, field} + 5'h01;
    endfunction

    // Correction alternates the longer phase between periods of an odd
    // division, so the average duty cycle is one half.
    always_comb begin
        oddPeriod = lowCycles[0] ^ highCycles[0];
        if (!duty_correction_disable && oddPeriod && swap) begin
            lenLow  = phaseLen(highCycles);
            lenHigh = phaseLen(lowCycles);
        end else begin
            lenLow  = phaseLen(lowCycles);
            lenHigh = phaseLen(highCycles);
        end
    end

    always_comb begin
        next_state  = state;
        next_cnt    = cnt;
        next_level  = level;
        next_swap   = swap;
        if (bypass) begin
            next_state = DIV_PHASE;
            next_cnt   = {1'b0, phaseOffset};
            next_level = startHigh;
        end else if (noSync && forceHigh) begin
            next_state = DIV_STATIC;
            next_level = 1'b1;
        end else if (syncEvt && !noSync) begin
            next_state = DIV_PHASE;
            next_cnt   = {1'b0, phaseOffset};
            next_level = startHigh;
            next_swap  = 1'b0;
        end else begin
            unique case (state)
                DIV_PHASE: begin
                    if (inEdge) begin
                        if (cnt == '0) begin
                            next_state = DIV_RUN;
                            next_cnt   = level ? lenHigh : lenLow;
                        end else begin
                            next_cnt = cnt - 5'h01;
                        end
                    end
                end
                DIV_RUN: begin
                    if (inEdge) begin
                        if (cnt == 5'h01) begin
                            next_level = !level;
                            next_cnt   = level ? lenLow : lenHigh;
                            if (level) begin
                                next_swap = !swap;
                            end
                        end else begin
                            next_cnt = cnt - 5'h01;
                        end
                    end
                end
                DIV_STATIC: begin
                    next_state = DIV_PHASE;
                    next_cnt   = {1'b0, phaseOffset};
                    next_level = startHigh;
                end
                default: begin
                    next_state = DIV_PHASE;
                    next_cnt   = '0;
                end
            endcase
        end
        next_divOut = bypass ? inLevel : level;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state  <= DIV_PHASE;
            cnt    <= '0;
            level  <= 1'b0;
            swap   <= 1'b0;
            divOut <= 1'b0;
        end else begin
            state  <= next_state;
            cnt    <= next_cnt;
            level  <= next_level;
            swap   <= next_swap;
            divOut <= next_divOut;
        end
    end

    assign running = (state == DIV_RUN);

endmodule

// [design/chd_out_route.sv]
`timescale 1ns/10ps
module chd_out_route (
    input  wire logic                      clock,
    input  wire logic                      rst_n,
    input  wire logic                      divLevel,
    input  wire logic                      oscLevel,
    input  wire logic                      extLevel,
    input  wire logic                      direct,
    input  wire logic [chd_pkg::SRC_W-1:0] srcSelect,
    output logic                           firstPin,
    output logic                           secondPin
);
    import chd_pkg::*;

    logic next_firstPin;

    always_comb begin
        next_firstPin = divLevel;
        if (direct && srcSelect == SRC_OSCILLATOR) begin
            next_firstPin = oscLevel;
        end else if (direct && srcSelect == SRC_EXT_CLOCK) begin
            next_firstPin = extLevel;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            firstPin  <= 1'b0;
            secondPin <= 1'b1;
        end else begin
            firstPin  <= next_firstPin;
            secondPin <= !next_firstPin;
        end
    end

endmodule

// [design/chd_pkg.sv]
package chd_pkg;

    localparam int unsigned ADDR_W = 12;
    localparam int unsigned REG_W  = 8;
    localparam int unsigned CNT_W  = 5;

    // ------------------------------------------------------------------
    // Register indices; the byte address is four times the index.
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] IDX_DIV1_COUNTS = 12'h193;
    localparam logic [ADDR_W-1:0] IDX_DIV1_POLPH  = 12'h194;
    localparam logic [ADDR_W-1:0] IDX_DIV1_ROUTE  = 12'h195;
    localparam logic [ADDR_W-1:0] IDX_DIV2_COUNTS = 12'h196;
    localparam logic [ADDR_W-1:0] IDX_DIV2_CTRL   = 12'h197;
    localparam logic [ADDR_W-1:0] IDX_DIV2_ROUTE  = 12'h198;
    localparam logic [ADDR_W-1:0] IDX_SRC_SELECT  = 12'h1e1;
    localparam logic [ADDR_W-1:0] IDX_STATUS      = 12'h1f0;

    // ------------------------------------------------------------------
    // Field positions.
    // ------------------------------------------------------------------
    localparam int unsigned BIT_BYPASS = 7;
    localparam int unsigned BIT_NOSYNC = 6;
    localparam int unsigned BIT_FORCE  = 5;
    localparam int unsigned BIT_START  = 4;
    localparam int unsigned PHASE_LSB  = 0;
    localparam int unsigned LOW_LSB    = 4;
    localparam int unsigned HIGH_LSB   = 0;
    localparam int unsigned NIB_W      = 4;
    localparam int unsigned BIT_DIRECT = 1;
    localparam int unsigned BIT_DUTY_OFF = 0;
    localparam int unsigned SRC_W      = 2;

    // ------------------------------------------------------------------
    // Reset values and source encodings.
    // ------------------------------------------------------------------
    localparam logic [REG_W-1:0] RST_DIV1_COUNTS = 8'h00;
    localparam logic [REG_W-1:0] RST_DIV1_POLPH  = 8'h00;
    localparam logic [REG_W-1:0] RST_ROUTE       = 8'h00;
    localparam logic [REG_W-1:0] RST_DIV2_COUNTS = 8'h00;
    localparam logic [REG_W-1:0] RST_DIV2_CTRL   = 8'h80;
    localparam logic [SRC_W-1:0] RST_SRC_SELECT  = 2'h1;
    localparam logic [SRC_W-1:0] SRC_EXT_CLOCK   = 2'h0;
    localparam logic [SRC_W-1:0] SRC_DISTRIB     = 2'h1;
    localparam logic [SRC_W-1:0] SRC_OSCILLATOR  = 2'h2;

    typedef enum logic [1:0] {
        DIV_PHASE  = 2'b00,
        DIV_RUN    = 2'b01,
        DIV_STATIC = 2'b11
    } chd_div_state_t;

endpackage

// [verif/chd_channel_dividers_bench.sv]
`timescale 1ns/10ps
module chd_channel_dividers_bench;
    import chd_pkg::*;
    logic        clock   = 1'b0;
    logic        rst_n   = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0;
    logic        fire    = 1'b0;
    logic [31:0] prdata, rd, wd;
    logic        pready, pslverr, err, distClk, osc, ext, syncReq_n;
    logic        pB, pBn, pC, pCn;
    int          failures, num_checks, cyc, seed, hi, lo, h2, l2;
    logic [3:0]  lc, hc;

    chd_clk_src src_u (.clock, .rst_n, .fire, .distClk, .osc, .ext,
        .syncReq_n);
    chd_channel_dividers dut_u (.clock, .rst_n, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .distClkIn(distClk),
        .oscIn(osc), .extClkIn(ext), .syncReq_n, .pairBFirstPin(pB),
        .pairBSecondPin(pBn), .pairCFirstPin(pC), .pairCSecondPin(pCn));

    initial begin
        forever #50 clock = !clock;
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    always @(posedge clock) begin
        cyc++;
        if (cyc == 60000) begin
            failures++;
            close_out();
        end
    end

    task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %0h seen %0h", nm, exp, got);
        end
    endtask

    task automatic apb(logic w, logic [11:0] ix, logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {ix[9:0], 2'b00};
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask

    function automatic logic lvl(bit c);
        return c ? pC : pB;
    endfunction

    // Times one high phase and the low phase after it, in clocks.
    task automatic meas(bit c, output int h, output int l);
        while (lvl(c) !== 1'b0) @(posedge clock);
        while (lvl(c) !== 1'b1) @(posedge clock);
        h = 0;
        l = 0;
        while (lvl(c) === 1'b1) begin
            @(posedge clock);
            h++;
        end
        while (lvl(c) === 1'b0) begin
            @(posedge clock);
            l++;
        end
    endtask

    task automatic sync_wait(int n);
        fire <= 1'b1;
        @(posedge clock);
        fire <= 1'b0;
        repeat (n) @(posedge clock);
    endtask

    logic [11:0] rIdx[7] = '{12'h193, 12'h194, 12'h195, 12'h196, 12'h197,
                             12'h198, 12'h1e1};
    logic [7:0]  rRst[7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h01};

    initial begin
        seed = 39929;
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, rIdx[i], 32'h0);
            chk("reset value", {24'h0, rRst[i]}, rd);
        end
        meas(1'b1, hi, lo);
        chk("bypass high", 32'd4, hi);
        meas(1'b0, hi, lo);
        chk("div1 default high", 32'd8, hi);
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            wd = 32'($random(seed)) & 32'hff;
            apb(1'b1, rIdx[i], wd);
            apb(1'b0, rIdx[i], 32'h0);
            chk("readback", wd, rd);
        end
        apb(1'b0, 12'h100, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, err});
        $display("test registers done");
        apb(1'b1, 12'h197, 32'h00);
        apb(1'b1, 12'h198, 32'h01);
        for (int i = 0; i < 4; i++) begin
            {lc, hc} = (i == 0) ? 8'hf0 : 8'($random(seed));
            apb(1'b1, 12'h196, {24'h0, lc, hc});
            meas(1'b1, hi, lo);
            meas(1'b1, hi, lo);
            chk("high phase", 32'((hc + 1) * 8), hi);
            chk("low phase", 32'((lc + 1) * 8), lo);
        end
        apb(1'b1, 12'h196, 32'h10);
        apb(1'b1, 12'h198, 32'h00);
        repeat (48) @(posedge clock);
        meas(1'b1, hi, lo);
        // Step on one period so the second measurement lands in the
        // other half of the two-period correction cycle.
        while (pC === 1'b1) @(posedge clock);
        while (pC === 1'b0) @(posedge clock);
        meas(1'b1, h2, l2);
        chk("corrected two periods", 32'd48, 32'(hi + lo + h2 + l2));
        chk("corrected highs", 32'd24, 32'(hi + h2));
        $display("test divider done");
        apb(1'b1, 12'h193, 32'h00);
        apb(1'b1, 12'h194, 32'h00);
        for (int s = 0; s < 3; s++) begin
            apb(1'b1, 12'h1e1, s);
            apb(1'b1, 12'h195, 32'h03);
            apb(1'b1, 12'h198, 32'h03);
            meas(1'b1, hi, lo);
            meas(1'b1, hi, lo);
            chk("pair C source", s == 0 ? 5 : s == 2 ? 3 : 8, hi);
            meas(1'b0, hi, lo);
            chk("pair B source", s == 0 ? 5 : s == 2 ? 3 : 8, hi);
        end
        apb(1'b1, 12'h195, 32'h00);
        meas(1'b0, hi, lo);
        meas(1'b0, hi, lo);
        chk("pair B divider", 32'd8, hi);
        $display("test routing done");
        apb(1'b1, 12'h1e1, 32'h1);
        apb(1'b1, 12'h197, 32'h60);
        repeat (30) @(posedge clock);
        chk("forced high", 32'h1, {31'h0, pC});
        repeat (50) @(posedge clock);
        chk("still forced", 32'h1, {31'h0, pC});
        apb(1'b1, 12'h197, 32'h20);
        meas(1'b1, hi, lo);
        meas(1'b1, hi, lo);
        chk("force needs nosync", 32'd24, hi + lo);
        $display("test force done");
        apb(1'b1, 12'h196, 32'hff);
        apb(1'b1, 12'h197, 32'h1f);
        sync_wait(200);
        chk("start high offset", 32'h1, {31'h0, pC});
        apb(1'b1, 12'h197, 32'h00);
        sync_wait(12);
        chk("start low", 32'h0, {31'h0, pC});
        apb(1'b1, 12'h197, 32'h50);
        while (pC !== 1'b1) @(posedge clock);
        while (pC !== 1'b0) @(posedge clock);
        sync_wait(12);
        chk("sync ignored", 32'h0, {31'h0, pC});
        $display("test sync done");
        close_out();
    end
endmodule

bind chd_channel_dividers chd_channel_dividers_sva sva_u (.clock, .rst_n,
    .psel, .penable, .paddr, .prdata, .pready, .pslverr, .pairBFirstPin,
    .pairBSecondPin, .pairCFirstPin, .pairCSecondPin);

// [verif/chd_channel_dividers_sva.sv]
`timescale 1ns/10ps
module chd_channel_dividers_sva
    import chd_pkg::*;
(
    input wire logic                       clock,
    input wire logic                       rst_n,
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic [chd_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0]                prdata,
    input wire logic                       pready,
    input wire logic                       pslverr,
    input wire logic                       pairBFirstPin,
    input wire logic                       pairBSecondPin,
    input wire logic                       pairCFirstPin,
    input wire logic                       pairCSecondPin
);
    logic [ADDR_W-1:0] idx;
    logic              acc;
    logic              mapped;

    assign idx    = paddr >> 2;
    assign acc    = psel && penable;
    assign mapped = idx inside {IDX_DIV1_COUNTS, IDX_DIV1_POLPH,
        IDX_DIV1_ROUTE, IDX_DIV2_COUNTS, IDX_DIV2_CTRL, IDX_DIV2_ROUTE,
        IDX_SRC_SELECT, IDX_STATUS};

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    AST_READY: assert property (acc |-> pready)
        else $error("pready low in access phase");
    AST_SETUP_IDLE: assert property (psel && !penable |-> !pready)
        else $error("pready high in setup phase");
    AST_DECODE: assert property (acc && paddr[1:0] == 2'b00 |->
        pslverr == !mapped)
        else $error("pslverr does not match address decode");
    AST_ERR_DATA: assert property (acc && pslverr |-> prdata == 32'h0)
        else $error("read data not zero on refused access");
    AST_UPPER_ZERO: assert property (acc |-> prdata[31:8] == 24'h0)
        else $error("upper read data bits not zero");
    AST_ERR_ACC: assert property (pslverr |-> acc)
        else $error("pslverr outside access phase");
    AST_PAIRB_COMP: assert property (pairBSecondPin != pairBFirstPin)
        else $error("pair B pins not complementary");
    AST_PAIRC_COMP: assert property (pairCSecondPin != pairCFirstPin)
        else $error("pair C pins not complementary");

    COV_REFUSED: cover property (acc && pslverr);
    COV_ACCEPTED: cover property (acc && !pslverr);
    COV_PAIRC_RISE: cover property ($rose(pairCFirstPin));
endmodule

// [verif/chd_clk_src.sv]
`timescale 1ns/10ps
module chd_clk_src (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic fire,
    output logic      distClk,
    output logic      osc,
    output logic      ext,
    output logic      syncReq_n
);
    // Half periods of 4, 3 and 5 clocks keep every source easy to tell
    // apart by the length of its high phase.
    int cnt;
    int hold;

    assign syncReq_n = (hold == 0);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt     <= 0;
            hold    <= 0;
            distClk <= 1'b0;
            osc     <= 1'b0;
            ext     <= 1'b0;
        end else begin
            cnt <= (cnt == 59) ? 0 : cnt + 1;
            if (cnt % 4 == 0) distClk <= !distClk;
            if (cnt % 3 == 0) osc <= !osc;
            if (cnt % 5 == 0) ext <= !ext;
            hold <= fire ? 4 : (hold != 0 ? hold - 1 : 0);
        end
    end
endmodule
